// File: logic/srx_pkg.sv
// Purpose: shared constants of the serial receive status and baud block
// Assumes: AHB-Lite byte addresses, one 32-bit word per register
// Notes:   status fields keep their bit positions in the low byte
package srx_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_STATUS1 = 8'h00;
  localparam logic [7:0] ADDR_STATUS2 = 8'h04;
  localparam logic [7:0] ADDR_CTRL3   = 8'h08;
  localparam logic [7:0] ADDR_BAUD    = 8'h0c;
  localparam logic [7:0] ADDR_FORMAT  = 8'h10;
  localparam logic [7:0] ADDR_DATA    = 8'h18;
  // primary status fields
  localparam int S1_FULL   = 5;
  localparam int S1_FRAME  = 1;
  localparam int S1_PARITY = 0;
  // secondary status fields
  localparam int S2_BREAK  = 1;
  localparam int S2_RXPROG = 0;
  // control three fields
  localparam int C3_NINTH  = 7;
  localparam int C3_FEIRQ  = 1;
  localparam int C3_PEIRQ  = 0;
  // format fields
  localparam int F_NINE    = 0;
  localparam int F_PAREN   = 1;
  localparam int F_PARODD  = 2;
  // baud select fields
  localparam int B_PRE_LO  = 4;
  localparam int B_DIV_LO  = 0;
  // reset values
  localparam logic [1:0] PRE_RST = 2'h0;
  localparam logic [2:0] DIV_RST = 3'h0;
  localparam logic [2:0] FMT_RST = 3'h0;
  // timing: sample ticks per bit, mid-bit slot, idle length in bits
  localparam int RT_PER_BIT = 16;
  localparam int RT_MID     = 7;
  localparam int IDLE_BITS  = 10;
  localparam int IDLE_TICKS = IDLE_BITS * RT_PER_BIT;
  // fixed part of the rate formula divided by sample ticks per bit
  localparam int PRE_BASE   = 64 / RT_PER_BIT;
  // receiver states
  typedef enum logic [1:0] {
    SRX_IDLE,
    SRX_START,
    SRX_DATA,
    SRX_STOP
  } srx_state_e;
endpackage : srx_pkg

// File: logic/srx_top.sv
// Purpose: receive status flags, data buffer and baud generator
// Assumes: all inputs synchronous to hclk, crystal clock sampled as a level
// Notes:   zero wait state AHB-Lite slave, read data registered
// Functional notes
// R1 - zero stop bit sets framing error
// R2 - framing error with enable raises error request
// R3 - framing error clears: status read, data read
// R4 - parity mismatch sets parity error
// R5 - parity error with enable raises request
// R6 - parity error clears: status read, data read
// R7 - reset clears framing, parity, break flags
// R8 - break sets break, framing, full flags
// R9 - break in nine-bit mode zeroes ninth bit
// R10 - break and progress flags raise nothing
// R11 - break clears: secondary read, data read
// R12 - break rearms only after a one
// R13 - zero in first slot sets progress
// R14 - false start or idle clears progress
// R15 - data reads received, writes transmit, no reset
// R16 - software avoids read-modify-write on data
// R17 - prescale field picks 1, 3, 4, 13
// R18 - divider field picks two to the field
// R19 - rate is source over 64*PD*BD
// R20 - crystal clock drives the baud generator
// R21 - reset zeroes prescale and divider fields
// R22 - character into buffer sets full flag
//
// Added by the designer: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module srx_top (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // serial side
  input  wire logic        crystal_clock_source,
  input  wire logic        receive_pin,
  // towards transmitter and cpu
  output logic             bit_rate_tick,
  output logic      [7:0]  tx_data,
  output logic             tx_load,
  output logic             serial_error_irq
);
  // prescaler divisor per select code
  function automatic logic [3:0] prescaler_divisor(input logic [1:0] sel);
    unique case (sel)
      2'h0: prescaler_divisor = 4'h1;
      2'h1: prescaler_divisor = 4'h3;
      2'h2: prescaler_divisor = 4'h4;
      2'h3: prescaler_divisor = 4'hd;
    endcase
  endfunction : prescaler_divisor

  // bus address phase decode
  logic             acc;          // valid transfer this cycle
  logic             rd_s1;        // primary status read taken
  logic             rd_s2;        // secondary status read taken
  logic             rd_dat;       // data buffer read taken
  // write data phase
  logic             wr_pend;      // write in data phase
  logic [7:0]       wr_addr;      // its address
  // configuration
  logic [1:0]       baud_prescale_select;
  logic [2:0]       baud_divider_select;
  logic [2:0]       fmt;          // nine-bit, parity enable, odd
  logic             framing_irq_enable;
  logic             parity_irq_enable;
  // flags and buffer
  logic             framing_error_flag;
  logic             parity_error_flag;
  logic             break_detect_flag;
  logic             receive_in_progress;
  logic             receive_full_flag;
  logic             received_ninth_bit;
  logic [7:0]       serial_data_buffer;
  logic             fe_arm, pe_arm, bk_arm, rf_arm;  // clear sequence armed
  logic             seen_one;     // line high since last break
  // baud generator
  logic             xtal_q;       // last crystal level
  logic [5:0]       pre_cnt;
  logic [6:0]       div_cnt;
  logic             pre_tick;
  logic             rt_tick;      // sixteen per bit
  logic [3:0]       bit_rt;       // ticks toward bit rate output
  // receiver
  srx_pkg::srx_state_e state;
  logic [3:0]       rt_cnt;
  logic [3:0]       bit_idx;
  logic [8:0]       shift;
  logic [7:0]       idle_cnt;
  logic             nbits_last;
  logic             par_bad;
  logic             load_ev;      // character lands in buffer
  logic             frame_ev;     // zero stop bit
  logic             break_ev;     // all zero character
  logic             par_ev;       // parity mismatch

  assign acc    = hsel & htrans[1] & hready;
  assign rd_s1  = acc & ~hwrite & (haddr == srx_pkg::ADDR_STATUS1);
  assign rd_s2  = acc & ~hwrite & (haddr == srx_pkg::ADDR_STATUS2);
  assign rd_dat = acc & ~hwrite & (haddr == srx_pkg::ADDR_DATA);

  // slave answers at once, always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // capture write address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= acc & hwrite;
      wr_addr <= haddr;
    end
  end

  // read data registered at the address phase edge, unmapped reads zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (acc && !hwrite) begin
      hrdata <= 32'h0000_0000;
      unique case (haddr)
        srx_pkg::ADDR_STATUS1: begin
          hrdata[srx_pkg::S1_FULL]   <= receive_full_flag;
          hrdata[srx_pkg::S1_FRAME]  <= framing_error_flag;
          hrdata[srx_pkg::S1_PARITY] <= parity_error_flag;
        end
        srx_pkg::ADDR_STATUS2: begin
          hrdata[srx_pkg::S2_BREAK]  <= break_detect_flag;
          hrdata[srx_pkg::S2_RXPROG] <= receive_in_progress;
        end
        srx_pkg::ADDR_CTRL3: begin
          hrdata[srx_pkg::C3_NINTH]  <= received_ninth_bit;
          hrdata[srx_pkg::C3_FEIRQ]  <= framing_irq_enable;
          hrdata[srx_pkg::C3_PEIRQ]  <= parity_irq_enable;
        end
        srx_pkg::ADDR_BAUD: begin
          hrdata[srx_pkg::B_PRE_LO +: 2] <= baud_prescale_select;
          hrdata[srx_pkg::B_DIV_LO +: 3] <= baud_divider_select;
        end
        srx_pkg::ADDR_FORMAT: hrdata[2:0] <= fmt;
        srx_pkg::ADDR_DATA:   hrdata[7:0] <= serial_data_buffer; // R15
        default:              hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // software configuration registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      baud_prescale_select <= srx_pkg::PRE_RST; // R21
      baud_divider_select  <= srx_pkg::DIV_RST; // R21
      fmt                  <= srx_pkg::FMT_RST;
      framing_irq_enable   <= 1'b0;
      parity_irq_enable    <= 1'b0;
    end else if (wr_pend) begin
      if (wr_addr == srx_pkg::ADDR_BAUD) begin
        baud_prescale_select <= hwdata[srx_pkg::B_PRE_LO +: 2];
        baud_divider_select  <= hwdata[srx_pkg::B_DIV_LO +: 3];
      end
      if (wr_addr == srx_pkg::ADDR_FORMAT) begin
        fmt <= hwdata[2:0];
      end
      if (wr_addr == srx_pkg::ADDR_CTRL3) begin
        framing_irq_enable <= hwdata[srx_pkg::C3_FEIRQ];
        parity_irq_enable  <= hwdata[srx_pkg::C3_PEIRQ];
      end
    end
  end

  // transmit byte handed on, separate from the receive buffer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_data <= 8'h00;
      tx_load <= 1'b0;
    end else begin
      tx_load <= wr_pend && (wr_addr == srx_pkg::ADDR_DATA); // R15
      if (wr_pend && (wr_addr == srx_pkg::ADDR_DATA)) begin
        tx_data <= hwdata[7:0]; // R15
      end
    end
  end

  // crystal edges counted through prescaler then divider
  assign pre_tick = (crystal_clock_source & ~xtal_q) && // R20
    (pre_cnt == 6'(srx_pkg::PRE_BASE * prescaler_divisor(baud_prescale_select) - 1)); // R17
  assign rt_tick  = pre_tick &&
    (div_cnt == 7'((8'h01 << baud_divider_select) - 8'h01)); // R18

  // baud counters; rate = source / (4*PD) / BD / 16
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      xtal_q  <= 1'b0;
      pre_cnt <= 6'h00;
      div_cnt <= 7'h00;
    end else begin
      xtal_q <= crystal_clock_source;
      if (pre_tick) begin
        pre_cnt <= 6'h00;
        div_cnt <= rt_tick ? 7'h00 : div_cnt + 7'h01; // R19
      end else if (crystal_clock_source && !xtal_q) begin
        pre_cnt <= pre_cnt + 6'h01; // R19
      end
    end
  end

  // bit rate pulse shared with the transmitter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bit_rt        <= 4'h0;
      bit_rate_tick <= 1'b0;
    end else begin
      bit_rate_tick <= rt_tick && (bit_rt == 4'(srx_pkg::RT_PER_BIT - 1)); // R19
      if (rt_tick) begin
        bit_rt <= bit_rt + 4'h1;
      end
    end
  end

  // character end conditions, evaluated at stop bit sample
  assign nbits_last = (bit_idx == (fmt[srx_pkg::F_NINE] ? 4'h8 : 4'h7));
  assign par_bad = fmt[srx_pkg::F_PAREN] &&
    ((^shift[8:0] ^ ~fmt[srx_pkg::F_NINE] & shift[8]) != fmt[srx_pkg::F_PARODD]); // R4
  assign frame_ev = rt_tick && (state == srx_pkg::SRX_STOP) &&
    (rt_cnt == 4'(srx_pkg::RT_PER_BIT - 1)) && !receive_pin; // R1
  assign break_ev = frame_ev && (shift == 9'h000);
  assign load_ev  = rt_tick && (state == srx_pkg::SRX_STOP) &&
    (rt_cnt == 4'(srx_pkg::RT_PER_BIT - 1)); // R22
  assign par_ev   = load_ev && !break_ev && par_bad; // R4

  // receive sequencer, sampling mid-bit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state   <= srx_pkg::SRX_IDLE;
      rt_cnt  <= 4'h0;
      bit_idx <= 4'h0;
      shift   <= 9'h000;
    end else if (rt_tick) begin
      unique case (state)
        srx_pkg::SRX_IDLE: begin
          rt_cnt  <= 4'h0;
          bit_idx <= 4'h0;
          if (!receive_pin) begin
            state <= srx_pkg::SRX_START;
          end
        end
        srx_pkg::SRX_START: begin
          rt_cnt <= rt_cnt + 4'h1;
          if (rt_cnt == 4'(srx_pkg::RT_MID)) begin
            rt_cnt <= 4'h0;
            // high at mid start is a false start
            state  <= receive_pin ? srx_pkg::SRX_IDLE : srx_pkg::SRX_DATA;
          end
        end
        srx_pkg::SRX_DATA: begin
          rt_cnt <= rt_cnt + 4'h1;
          if (rt_cnt == 4'(srx_pkg::RT_PER_BIT - 1)) begin
            // lsb first into the low end
            shift[bit_idx] <= receive_pin;
            bit_idx        <= bit_idx + 4'h1;
            if (nbits_last) begin
              state <= srx_pkg::SRX_STOP;
            end
          end
        end
        srx_pkg::SRX_STOP: begin
          rt_cnt <= rt_cnt + 4'h1;
          if (rt_cnt == 4'(srx_pkg::RT_PER_BIT - 1)) begin
            state <= srx_pkg::SRX_IDLE;
            shift <= 9'h000;
          end
        end
      endcase
    end
  end

  // consecutive high ticks while idle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      idle_cnt <= 8'h00;
    end else if (rt_tick) begin
      if (!receive_pin || state != srx_pkg::SRX_IDLE) begin
        idle_cnt <= 8'h00;
      end else if (idle_cnt != 8'(srx_pkg::IDLE_TICKS)) begin
        idle_cnt <= idle_cnt + 8'h01;
      end
    end
  end

  // reception in progress, no request from it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      receive_in_progress <= 1'b0;
    end else if (rt_tick) begin
      if (state == srx_pkg::SRX_IDLE && !receive_pin) begin
        receive_in_progress <= 1'b1; // R13
      end else if (state == srx_pkg::SRX_START && rt_cnt == 4'(srx_pkg::RT_MID)
                   && receive_pin) begin
        receive_in_progress <= 1'b0; // R14
      end else if (idle_cnt == 8'(srx_pkg::IDLE_TICKS - 1) && receive_pin
                   && state == srx_pkg::SRX_IDLE) begin
        receive_in_progress <= 1'b0; // R14
      end
    end
  end

  // buffer and ninth bit, untouched by reset
  always_ff @(posedge hclk) begin
    if (load_ev) begin
      serial_data_buffer <= shift[7:0]; // R15
      if (break_ev) begin
        received_ninth_bit <= 1'b0; // R9
      end else begin
        received_ninth_bit <= fmt[srx_pkg::F_NINE] ? shift[8] : shift[7];
      end
    end
  end

  // clear sequence: status read with flag set arms, data read clears
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fe_arm <= 1'b0;
      pe_arm <= 1'b0;
      rf_arm <= 1'b0;
      bk_arm <= 1'b0;
    end else begin
      fe_arm <= rd_s1 ? framing_error_flag : (rd_dat ? 1'b0 : fe_arm); // R3
      pe_arm <= rd_s1 ? parity_error_flag  : (rd_dat ? 1'b0 : pe_arm); // R6
      rf_arm <= rd_s1 ? receive_full_flag  : (rd_dat ? 1'b0 : rf_arm);
      bk_arm <= rd_s2 ? break_detect_flag  : (rd_dat ? 1'b0 : bk_arm); // R11
    end
  end

  // sticky flags, a new event wins over a clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      framing_error_flag <= 1'b0; // R7
      parity_error_flag  <= 1'b0; // R7
      break_detect_flag  <= 1'b0; // R7
      receive_full_flag  <= 1'b0;
    end else begin
      if (frame_ev) begin
        framing_error_flag <= 1'b1; // R1 R8
      end else if (rd_dat && fe_arm) begin
        framing_error_flag <= 1'b0; // R3
      end
      if (par_ev) begin
        parity_error_flag <= 1'b1; // R4
      end else if (rd_dat && pe_arm) begin
        parity_error_flag <= 1'b0; // R6
      end
      if (break_ev && seen_one) begin
        break_detect_flag <= 1'b1; // R8 R12
      end else if (rd_dat && bk_arm) begin
        break_detect_flag <= 1'b0; // R11
      end
      if (load_ev) begin
        receive_full_flag <= 1'b1; // R22 R8
      end else if (rd_dat && rf_arm) begin
        receive_full_flag <= 1'b0;
      end
    end
  end

  // line must go high again before the next break counts
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seen_one <= 1'b1;
    end else if (break_ev) begin
      seen_one <= 1'b0; // R12
    end else if (rt_tick && receive_pin) begin
      seen_one <= 1'b1; // R12
    end
  end

  // error request only from framing and parity
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      serial_error_irq <= 1'b0;
    end else begin
      serial_error_irq <= (framing_error_flag & framing_irq_enable) | // R2 R10
                          (parity_error_flag & parity_irq_enable);    // R5
    end
  end
endmodule : srx_top
`default_nettype wire

// File: bench/srx_checker.sv
// Purpose: port checker for srx_top
// Assumes: one hclk domain, asynchronous active low reset
// Notes:   attached by the bind at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module srx_checker (
  // clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // bus side
  input wire logic        hsel,
  input wire logic [7:0]  haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // serial side and outputs
  input wire logic        crystal_clock_source,
  input wire logic        receive_pin,
  input wire logic        bit_rate_tick,
  input wire logic [7:0]  tx_data,
  input wire logic        tx_load,
  input wire logic        serial_error_irq
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire logic take = hsel && htrans[1] && hready;  // request taken
  wire logic wr_d = take && hwrite && haddr == srx_pkg::ADDR_DATA;  // data write
  wire logic clr_c = take && (haddr == srx_pkg::ADDR_DATA && !hwrite
                     || haddr == srx_pkg::ADDR_CTRL3 && hwrite);  // may drop irq
  logic       xprev;  // last crystal level
  logic [4:0] quiet;  // cycles since a crystal rise
  logic [2:0] since;  // cycles since a possible irq clear
  // crystal rise tracking
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      xprev <= 1'b0;
      quiet <= 5'h1f;
    end else begin
      xprev <= crystal_clock_source;
      if (crystal_clock_source && !xprev) quiet <= 5'h00;
      else if (quiet != 5'h1f) quiet <= quiet + 5'h01;
    end
  end
  // age of the last clear cause
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) since <= 3'h7;
    else if (clr_c) since <= 3'h0;
    else if (since != 3'h7) since <= since + 3'h1;
  end
  // write address phase, then its data phase
  sequence wr_data_s;
    wr_d ##1 1'b1;
  endsequence
  a_write_loads_tx: assert property (wr_data_s |=> tx_load && tx_data == $past(hwdata[7:0]))
    else $error("data write gave no transmit load");
  a_load_has_cause: assert property (tx_load |-> $past(wr_d, 2))
    else $error("transmit load without data write");
  a_ready_always: assert property ($past(hresetn) |-> hreadyout)
    else $error("slave inserted a wait state");
  a_resp_okay: assert property (!hresp)
    else $error("slave gave an error response");
  a_read_upper_zero: assert property (take && !hwrite |=> hrdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  a_unmapped_zero: assert property (take && !hwrite && haddr == 8'h14 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_tick_single: assert property (bit_rate_tick |=> (!bit_rate_tick) [*8])
    else $error("bit rate tick too long");
  a_tick_crystal: assert property (bit_rate_tick |-> quiet < 5'h08)
    else $error("bit rate tick without crystal");
  a_irq_clear_cause: assert property ($fell(serial_error_irq) |-> since < 3'h4)
    else $error("error request dropped by itself");
endmodule : srx_checker
bind srx_top srx_checker chk_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .crystal_clock_source(crystal_clock_source), .receive_pin(receive_pin),
  .bit_rate_tick(bit_rate_tick), .tx_data(tx_data), .tx_load(tx_load),
  .serial_error_irq(serial_error_irq));
`default_nettype wire

// File: bench/srx_tx_model.sv
// Purpose: remote asynchronous transmitter on the receive line
// Assumes: a bit lasts a whole number of hclk cycles
// Notes:   line idles high; changes land just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module srx_tx_model #(
  parameter int BIT_CYC = 256  // hclk cycles per bit
) (
  // clock
  input  wire logic hclk,
  // serial line
  output var logic  receive_pin
);
  initial receive_pin = 1'b1;
  // hold one level for a number of cycles
  task automatic level(input logic v, input int cyc);
    receive_pin <= v;
    repeat (cyc) @(posedge hclk);
  endtask : level
  // start, data lsb first, stop, then back to idle
  task automatic send(input logic [8:0] d, input int nb, input logic stop);
    level(1'b0, BIT_CYC);
    for (int i = 0; i < nb; i++) level(d[i], BIT_CYC);
    level(stop, BIT_CYC);
    level(1'b1, 0);
  endtask : send
endmodule : srx_tx_model
`default_nettype wire

// File: bench/tb.sv
// Purpose: self-checking bench for srx_top
// Assumes: crystal at a quarter of hclk, fastest rate for frames
// Notes:   every scenario judges its own results
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int XDIV = 4;          // hclk cycles per crystal period
  localparam int BITC = 64 * XDIV;  // bit time at the fastest rate
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [7:0]  haddr = 8'h00;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rv;          // read data, last read word
  logic        hreadyout, hresp, bit_rate_tick, tx_load, irq;
  logic [7:0]  tx_data;
  logic [1:0]  xcnt = 2'h0;         // crystal divider
  logic        xrun = 1'b1;         // crystal running
  wire logic   rx_line;
  int          err_total = 0;
  int          check_count = 0;
  always #12.5 hclk = ~hclk;
  // crystal clock made from hclk
  always @(posedge hclk) if (xrun) xcnt <= xcnt + 2'h1;
  srx_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .crystal_clock_source(xcnt[1]),
    .receive_pin(rx_line), .bit_rate_tick(bit_rate_tick), .tx_data(tx_data),
    .tx_load(tx_load), .serial_error_irq(irq));
  srx_tx_model #(.BIT_CYC(BITC)) tx_u (.hclk(hclk), .receive_pin(rx_line));
  // verdict and end of run
  task automatic report_and_stop();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop
  // compare and count
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  // bounded wait for a signal high at a rising edge
  task automatic wt(ref logic s, input int lim, input bit must, output int n);
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (s !== 1'b1 && n < lim);
    if (must && s !== 1'b1) begin
      err_total++;
      $display("[ERR] %0t wait ran out", $time);
      report_and_stop();
    end
  endtask : wt
  // one single word transfer, address phase then data phase
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    wt(hreadyout, 16, 1, n);
    htrans <= 2'h0;
    hwdata <= d;
    wt(hreadyout, 16, 1, n);
    rv = hrdata;
  endtask : bus
  // masked read and compare
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rv & m, e);
  endtask : rdc
  task automatic do_reset();
    hresetn <= 1'b0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
  endtask : do_reset
  // rate per prescale setting and divider settings 0 to 4, then crystal stopped
  task automatic t_baud();
    int pd [4] = '{1, 3, 4, 13};
    int n, p, d;
    for (int i = 0; i < 8; i++) begin
      p = (i < 4) ? i : 0;
      d = (i < 4) ? 0 : i - 3;
      bus(1'b1, srx_pkg::ADDR_BAUD, 32'((p << srx_pkg::B_PRE_LO) | d));
      wt(bit_rate_tick, 20000, 1, n);
      wt(bit_rate_tick, 20000, 1, n);
      chk(32'(n), 32'(64 * pd[p] * (1 << d) * XDIV));
    end
    xrun <= 1'b0;
    wt(bit_rate_tick, 5000, 0, n);
    chk(32'(n), 32'd5000);
    xrun <= 1'b1;
  endtask : t_baud
  // short low pulse is a false start
  task automatic t_false();
    fork
      tx_u.level(1'b0, 64);
      begin
        repeat (40) @(posedge hclk);
        rdc(srx_pkg::ADDR_STATUS2, 32'h1, 32'h1);
      end
    join
    tx_u.level(1'b1, 200);
    rdc(srx_pkg::ADDR_STATUS2, 32'h1, 32'h0);
  endtask : t_false
  // clean character, buffer access, idle line
  task automatic t_good();
    bus(1'b1, srx_pkg::ADDR_DATA, 32'h5a);
    @(posedge hclk);
    chk(32'(tx_data), 32'h5a);
    tx_u.send(9'ha5, 8, 1'b1);
    rdc(srx_pkg::ADDR_STATUS1, 32'h23, 32'h20);
    rdc(srx_pkg::ADDR_DATA, 32'hff, 32'ha5);
    rdc(srx_pkg::ADDR_CTRL3, 32'h83, 32'h80);
    rdc(srx_pkg::ADDR_STATUS1, 32'h23, 32'h00);
    repeat (11 * BITC) @(posedge hclk);
    rdc(srx_pkg::ADDR_STATUS2, 32'h1, 32'h0);
  endtask : t_good
  // low stop bit, request, clear order
  task automatic t_fe();
    bus(1'b1, srx_pkg::ADDR_CTRL3, 32'h2);
    tx_u.send(9'h55, 8, 1'b0);
    repeat (4) @(posedge hclk);
    chk(32'(irq), 32'h1);
    rdc(srx_pkg::ADDR_DATA, 32'hff, 32'h55);
    rdc(srx_pkg::ADDR_STATUS1, 32'h23, 32'h22);
    rdc(srx_pkg::ADDR_DATA, 32'hff, 32'h55);
    repeat (3) @(posedge hclk);
    chk(32'(irq), 32'h0);
    rdc(srx_pkg::ADDR_STATUS1, 32'h23, 32'h00);
  endtask : t_fe
  // even parity: good then bad character
  task automatic t_par();
    bus(1'b1, srx_pkg::ADDR_CTRL3, 32'h1);
    bus(1'b1, srx_pkg::ADDR_FORMAT, 32'h2);
    tx_u.send(9'h03, 8, 1'b1);
    rdc(srx_pkg::ADDR_STATUS1, 32'h23, 32'h20);
    rdc(srx_pkg::ADDR_DATA, 32'hff, 32'h03);
    tx_u.send(9'h01, 8, 1'b1);
    repeat (4) @(posedge hclk);
    chk(32'(irq), 32'h1);
    rdc(srx_pkg::ADDR_STATUS1, 32'h23, 32'h21);
    rdc(srx_pkg::ADDR_DATA, 32'hff, 32'h01);
    repeat (3) @(posedge hclk);
    chk(32'(irq), 32'h0);
    rdc(srx_pkg::ADDR_STATUS1, 32'h23, 32'h00);
    // odd parity: a single one is a good character
    bus(1'b1, srx_pkg::ADDR_FORMAT, 32'h6);
    tx_u.send(9'h01, 8, 1'b1);
    rdc(srx_pkg::ADDR_STATUS1, 32'h23, 32'h20);
    rdc(srx_pkg::ADDR_DATA, 32'hff, 32'h01);
  endtask : t_par
  // nine-bit break, clear, rearm only after a high line
  task automatic t_brk();
    int n;
    bus(1'b1, srx_pkg::ADDR_CTRL3, 32'h0);
    bus(1'b1, srx_pkg::ADDR_FORMAT, 32'h1);
    tx_u.send(9'h180, 9, 1'b1);
    rdc(srx_pkg::ADDR_CTRL3, 32'h80, 32'h80);
    // break held low from here on, so no one reaches the line before the rearm test
    tx_u.level(1'b0, 11 * BITC);
    repeat (4) @(posedge hclk);
    chk(32'(irq), 32'h0);
    rdc(srx_pkg::ADDR_STATUS1, 32'h23, 32'h22);
    rdc(srx_pkg::ADDR_CTRL3, 32'h80, 32'h00);
    rdc(srx_pkg::ADDR_STATUS2, 32'h2, 32'h2);
    rdc(srx_pkg::ADDR_DATA, 32'hff, 32'h00);
    rdc(srx_pkg::ADDR_STATUS2, 32'h2, 32'h0);
    fork
      tx_u.level(1'b0, 24 * BITC);
      begin
        n = 0;
        do begin
          bus(1'b0, srx_pkg::ADDR_STATUS2, 32'h0);
          n++;
        end while (rv[1] !== 1'b1 && n < 2000);
        // further breaks on a line that never went high must not set the flag
        chk(32'(rv[1]), 32'h0);
        bus(1'b0, srx_pkg::ADDR_DATA, 32'h0);
      end
    join
    tx_u.level(1'b1, 12 * BITC);
    rdc(srx_pkg::ADDR_STATUS2, 32'h2, 32'h0);
    tx_u.send(9'h000, 9, 1'b0);
    rdc(srx_pkg::ADDR_STATUS2, 32'h2, 32'h2);
  endtask : t_brk
  // main sequence
  initial begin
    do_reset();
    rdc(srx_pkg::ADDR_STATUS1, 32'h23, 32'h0);
    rdc(srx_pkg::ADDR_BAUD, 32'hff, 32'h0);
    rdc(8'h14, 32'hffffffff, 32'h0);
    t_baud();
    do_reset();
    rdc(srx_pkg::ADDR_BAUD, 32'hff, 32'h0);
    t_false();
    t_good();
    do_reset();
    rdc(srx_pkg::ADDR_DATA, 32'hff, 32'ha5);
    t_fe();
    t_par();
    t_brk();
    do_reset();
    rdc(srx_pkg::ADDR_STATUS1, 32'h23, 32'h0);
    rdc(srx_pkg::ADDR_STATUS2, 32'h2, 32'h0);
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
